/* analog_front.sv */
// behavioural analog front end: trim codes compared against fixed thresholds AMP_TH and CMP_TH, or the external level
`timescale 1ns/1ps
module analog_front #(
  parameter int AMP_TH = 23,
  parameter int CMP_TH = 9
) (
  // controls
  input  wire logic       amp_cal_mode,
  input  wire logic       comp_cal_mode,
  input  wire logic [5:0] amp_trim_code,
  input  wire logic [4:0] comp_trim_code,
  input  wire logic       comp_pos_input_sel,
  input  wire logic       ext_level,
  // result
  output logic            comp_in
);
  // offset modelled as a trim threshold; ideal, no noise near the step
  always_comb begin
    if (comp_pos_input_sel) comp_in = ext_level;
    else if (amp_cal_mode) comp_in = amp_trim_code >= 6'(AMP_TH);
    else if (comp_cal_mode) comp_in = comp_trim_code >= 5'(CMP_TH);
    else comp_in = 1'b0;
  end
endmodule : analog_front

/* comp_sync.sv */
// two-stage synchroniser with protection-enable gating for the comparator
`timescale 1ns/1ps
module comp_sync (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // comparator
  input  wire logic comp_in,
  input  wire logic enable,
  output logic      comp_raw_out
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= comp_in;
      sync_q <= meta_q;
    end
  end

  // gated after sync so a disable shows one edge later, without passing the two sync stages
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      comp_raw_out <= 1'b0;
    end else begin
      comp_raw_out <= enable & sync_q;
    end
  end
endmodule : comp_sync

/* protect_trim.sv */
// register file and analog control outputs for the protection trim block
//
// The register addresses and the strobed register port were decided locally.
`timescale 1ns/1ps
`include "protect_trim_regs.svh"
module protect_trim (
  // clock and reset
  input  wire logic                        clk,
  input  wire logic                        rst,
  // register port
  input  wire protect_trim_pkg::reg_addr_t addr,
  input  wire protect_trim_pkg::reg_byte_t wdata,
  input  wire logic                        wr_en,
  input  wire logic                        rd_en,
  output protect_trim_pkg::reg_byte_t      rdata,
  // analog comparator result (asynchronous)
  input  wire logic                        comp_in,
  // analog controls
  output logic [7:0]                       switch_ctrl,
  output logic [7:0]                       threshold_dac_code,
  output logic                             protect_enable,
  output logic                             comp_hyst_en,
  output logic                             comp_pos_input_sel,
  output logic                             amp_cal_mode,
  output logic                             amp_cal_ref_sel,
  output logic [5:0]                       amp_trim_code,
  output logic                             comp_cal_mode,
  output logic                             comp_cal_ref_sel,
  output logic [4:0]                       comp_trim_code,
  // comparator result pin
  output logic                             comp_out_pin
);
  import protect_trim_pkg::*;

  reg_byte_t sw_q;
  reg_byte_t ctrl1_q;
  reg_byte_t dac_q;
  reg_byte_t amp_q;
  reg_byte_t comp_q;
  reg_byte_t sw_eff_d;
  reg_byte_t rdata_d;
  logic      comp_raw_out;

  // reset images, so the output flops reset to the same fields as the registers
  localparam reg_byte_t AMP_RST  = `RST_AMP_TRIM;
  localparam reg_byte_t COMP_RST = `RST_COMP_TRIM;
  localparam reg_byte_t CTRL_RST = `RST_CTRL1;

  // switch pattern; the sweeps themselves are left to the controller
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sw_q <= `RST_SWITCH_CTRL;
    end else if (wr_en && addr == `ADDR_SWITCH_CTRL) begin
      sw_q <= wdata;
    end
  end

  // control byte; bits 5..2 are not stored and read back as zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl1_q <= `RST_CTRL1;
    end else if (wr_en && addr == `ADDR_CTRL1) begin
      ctrl1_q <= wdata & `CTRL1_WMASK;
    end
  end

  // threshold dac code
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dac_q <= `RST_DAC_CODE;
    end else if (wr_en && addr == `ADDR_DAC_CODE) begin
      dac_q <= wdata;
    end
  end

  // amplifier trim: mode, reference and six-bit code
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      amp_q <= `RST_AMP_TRIM;
    end else if (wr_en && addr == `ADDR_AMP_TRIM) begin
      amp_q <= wdata;
    end
  end

  // comparator trim: bit 7 is never stored, reads show the live result
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      comp_q <= `RST_COMP_TRIM;
    end else if (wr_en && addr == `ADDR_COMP_TRIM) begin
      comp_q <= {1'b0, wdata[6:0]};
    end
  end

  comp_sync u_sync (
    .clk          (clk),
    .rst          (rst),
    .comp_in      (comp_in),
    .enable       (ctrl1_q[`BIT_PROT_EN]),
    .comp_raw_out (comp_raw_out)
  );

  // unity gain: S6..S4 forced off when all three are zero
  always_comb begin
    sw_eff_d = sw_q;
    if ((sw_q & `UNITY_MASK) == 8'h00) begin
      sw_eff_d = sw_q & ~`UNITY_MASK;
    end
  end

  // reads see the comparator bit live in position 7
  always_comb begin
    rdata_d = 8'h00;
    if (rd_en) begin
      unique case (addr)
        `ADDR_SWITCH_CTRL: rdata_d = sw_q;
        `ADDR_CTRL1:       rdata_d = ctrl1_q;
        `ADDR_DAC_CODE:    rdata_d = dac_q;
        `ADDR_AMP_TRIM:    rdata_d = amp_q;
        `ADDR_COMP_TRIM:   rdata_d = {comp_raw_out, comp_q[6:0]};
        default:           rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rdata_d;
    end
  end

  // switch and dac outputs, registered so they come straight from flops
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      switch_ctrl        <= `RST_SWITCH_CTRL;
      threshold_dac_code <= `RST_DAC_CODE;
    end else begin
      switch_ctrl        <= sw_eff_d;
      threshold_dac_code <= dac_q;
    end
  end

  // protection enable, hysteresis and comparator input select
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      protect_enable     <= CTRL_RST[`BIT_PROT_EN];
      comp_hyst_en       <= CTRL_RST[`BIT_HYST_EN];
      comp_pos_input_sel <= CTRL_RST[`BIT_POS_SEL];
    end else begin
      protect_enable     <= ctrl1_q[`BIT_PROT_EN];
      comp_hyst_en       <= ctrl1_q[`BIT_HYST_EN];
      comp_pos_input_sel <= ctrl1_q[`BIT_POS_SEL];
    end
  end

  // amplifier trim fields
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      amp_cal_mode    <= AMP_RST[`BIT_AMP_CAL_MODE];
      amp_cal_ref_sel <= AMP_RST[`BIT_AMP_REF_SEL];
      amp_trim_code   <= AMP_RST[5:0];
    end else begin
      amp_cal_mode    <= amp_q[`BIT_AMP_CAL_MODE];
      amp_cal_ref_sel <= amp_q[`BIT_AMP_REF_SEL];
      amp_trim_code   <= amp_q[5:0];
    end
  end

  // comparator trim fields
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      comp_cal_mode    <= COMP_RST[`BIT_COMP_CAL_MODE];
      comp_cal_ref_sel <= COMP_RST[`BIT_COMP_REF_SEL];
      comp_trim_code   <= COMP_RST[4:0];
    end else begin
      comp_cal_mode    <= comp_q[`BIT_COMP_CAL_MODE];
      comp_cal_ref_sel <= comp_q[`BIT_COMP_REF_SEL];
      comp_trim_code   <= comp_q[4:0];
    end
  end

  // pin takes the gated result at the same edge as the read data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      comp_out_pin <= 1'b0;
    end else begin
      comp_out_pin <= comp_raw_out;
    end
  end

  // a write lands at the strobe edge and reaches its output one edge later
  a_unity_gain: assert property (@(posedge clk) disable iff (rst)
    (sw_q[6:4] == 3'b000)
    |=> (switch_ctrl[6:4] == 3'b000))
    else $error("unity gain switches not off");

  a_switch_follow: assert property (@(posedge clk) disable iff (rst)
    (sw_q[6:4] != 3'b000)
    |=> (switch_ctrl == $past(sw_q)))
    else $error("switch pattern not passed on");

  a_amp_mode_follow: assert property (@(posedge clk) disable iff (rst)
    (wr_en && addr == `ADDR_AMP_TRIM)
    |=> ##1 (amp_cal_mode == $past(wdata[7], 2)))
    else $error("amp cal mode mismatch");

  a_amp_ref_follow: assert property (@(posedge clk) disable iff (rst)
    (wr_en && addr == `ADDR_AMP_TRIM)
    |=> ##1 (amp_cal_ref_sel == $past(wdata[6], 2)))
    else $error("amp ref select mismatch");

  a_amp_trim_follow: assert property (@(posedge clk) disable iff (rst)
    (wr_en && addr == `ADDR_AMP_TRIM)
    |=> ##1 (amp_trim_code == $past(wdata[5:0], 2)))
    else $error("amp trim code mismatch");

  a_amp_reset_value: assert property (@(posedge clk) disable iff (rst)
    $fell(rst)
    |-> (amp_q == AMP_RST && amp_trim_code == AMP_RST[5:0]))
    else $error("amp trim reset value wrong");

  a_amp_read_back: assert property (@(posedge clk) disable iff (rst)
    (rd_en && addr == `ADDR_AMP_TRIM)
    |=> (rdata == $past(amp_q)))
    else $error("amp trim read back wrong");

  a_comp_mode_follow: assert property (@(posedge clk) disable iff (rst)
    (wr_en && addr == `ADDR_COMP_TRIM)
    |=> ##1 (comp_cal_mode == $past(wdata[6], 2)))
    else $error("comp cal mode mismatch");

  a_comp_ref_follow: assert property (@(posedge clk) disable iff (rst)
    (wr_en && addr == `ADDR_COMP_TRIM)
    |=> ##1 (comp_cal_ref_sel == $past(wdata[5], 2)))
    else $error("comp ref select mismatch");

  a_comp_trim_follow: assert property (@(posedge clk) disable iff (rst)
    (wr_en && addr == `ADDR_COMP_TRIM)
    |=> ##1 (comp_trim_code == $past(wdata[4:0], 2)))
    else $error("comp trim code mismatch");

  a_comp_reset_value: assert property (@(posedge clk) disable iff (rst)
    $fell(rst)
    |-> (comp_q == COMP_RST && comp_trim_code == COMP_RST[4:0]))
    else $error("comp trim reset value wrong");

  a_comp_bit_readonly: assert property (@(posedge clk) disable iff (rst)
    (wr_en && addr == `ADDR_COMP_TRIM)
    |=> (comp_q[7] == 1'b0))
    else $error("comp result bit was written");

  a_comp_read_live: assert property (@(posedge clk) disable iff (rst)
    (rd_en && addr == `ADDR_COMP_TRIM)
    |=> (rdata == {$past(comp_raw_out), $past(comp_q[6:0])}))
    else $error("comp trim read back wrong");

  a_pin_matches_bit: assert property (@(posedge clk) disable iff (rst)
    (rd_en && addr == `ADDR_COMP_TRIM)
    |=> (comp_out_pin == rdata[7]))
    else $error("pin and read bit differ");

  a_disabled_reads_zero: assert property (@(posedge clk) disable iff (rst)
    (!ctrl1_q[`BIT_PROT_EN] && $past(!ctrl1_q[`BIT_PROT_EN]) && rd_en
     && addr == `ADDR_COMP_TRIM) |=> (rdata[7] == 1'b0))
    else $error("comp bit not zero while disabled");

  a_disabled_raw_zero: assert property (@(posedge clk) disable iff (rst)
    (!$past(ctrl1_q[`BIT_PROT_EN]))
    |-> (comp_raw_out == 1'b0))
    else $error("raw comp result not zero while disabled");

  a_disabled_pin_zero: assert property (@(posedge clk) disable iff (rst)
    (!$past(ctrl1_q[`BIT_PROT_EN], 2))
    |-> (comp_out_pin == 1'b0))
    else $error("comp pin not zero while disabled");

  a_enable_follow: assert property (@(posedge clk) disable iff (rst)
    (wr_en && addr == `ADDR_CTRL1)
    |=> ##1 (protect_enable == $past(wdata[7], 2)))
    else $error("protection enable mismatch");

  a_pos_sel_follow: assert property (@(posedge clk) disable iff (rst)
    (wr_en && addr == `ADDR_CTRL1)
    |=> ##1 (comp_pos_input_sel == $past(wdata[1], 2)))
    else $error("comp input select mismatch");

  a_ctrl_bits_masked: assert property (@(posedge clk) disable iff (rst)
    (wr_en && addr == `ADDR_CTRL1)
    |=> (ctrl1_q[5:2] == 4'h0))
    else $error("unused control bits were stored");

  a_idle_read_zero: assert property (@(posedge clk) disable iff (rst)
    (!rd_en)
    |=> (rdata == 8'h00))
    else $error("read data not zero outside a read");

  c_amp_cal_entry: cover property (@(posedge clk) disable iff (rst)
    amp_cal_mode && !comp_cal_mode && switch_ctrl == 8'h28);
  c_comp_cal_entry: cover property (@(posedge clk) disable iff (rst)
    comp_cal_mode && !amp_cal_mode && switch_ctrl == 8'h28);
  c_comp_toggle: cover property (@(posedge clk) disable iff (rst)
    $rose(comp_out_pin));
  c_unity_buffer: cover property (@(posedge clk) disable iff (rst)
    sw_q[6:4] == 3'b000 && sw_q[7]);
  c_ext_input: cover property (@(posedge clk) disable iff (rst)
    comp_pos_input_sel && comp_out_pin);
endmodule : protect_trim

/* protect_trim_pkg.sv */
// types shared by the protection trim block
package protect_trim_pkg;
  typedef logic [7:0] reg_byte_t;
  typedef logic [2:0] reg_addr_t;
endpackage : protect_trim_pkg

/* protect_trim_regs.svh */
// register offsets, field positions, reset values for the protection trim block
// Function
// - amplifier trim bit 7 selects normal (0) or offset calibration (1) mode
// - amplifier trim bit 6 picks calibration reference: 0 inverting, 1 non-inverting
// - amplifier trim low six bits hold writable trim code, reset value 0x20
// - comparator trim bit 7 read-only comparator output, also driven to a pin
// - comparator trim bit 6 selects normal (0) or offset calibration (1) mode
// - comparator trim bit 5 picks calibration reference: 0 inverting, 1 non-inverting
// - comparator trim low five bits hold writable trim code, reset value 0x10
// - switch bits 6..4 all zero force S6..S4 off, unity-gain buffer
// - protection enable 0 disables function; raw comparator bit reads 0
// - comp input select 0 routes amplifier output, 1 routes external pin
`ifndef PROTECT_TRIM_REGS_SVH
`define PROTECT_TRIM_REGS_SVH
`define ADDR_SWITCH_CTRL   3'h0
`define ADDR_CTRL1         3'h1
`define ADDR_DAC_CODE      3'h2
`define ADDR_AMP_TRIM      3'h3
`define ADDR_COMP_TRIM     3'h4
`define RST_SWITCH_CTRL    8'hC8
`define RST_CTRL1          8'h00
`define RST_DAC_CODE       8'h00
`define RST_AMP_TRIM       8'h20
`define RST_COMP_TRIM      8'h10
`define BIT_AMP_CAL_MODE   7
`define BIT_AMP_REF_SEL    6
`define BIT_COMP_OUT       7
`define BIT_COMP_CAL_MODE  6
`define BIT_COMP_REF_SEL   5
`define BIT_PROT_EN        7
`define BIT_HYST_EN        6
`define BIT_POS_SEL        1
`define CTRL1_WMASK        8'hC3
`define UNITY_MASK         8'h70
`endif

/* tb.sv */
// self-checking bench for the protection trim registers
`timescale 1ns/1ps
module tb;
  import protect_trim_pkg::*;
  localparam int AMP_TH = 23;
  localparam int CMP_TH = 9;
  logic       clk = 1'b0;
  logic       rst, wr_en, rd_en, ext_level, comp_in;
  reg_addr_t  addr;
  reg_byte_t  wdata, rdata;
  logic [7:0] switch_ctrl, threshold_dac_code;
  logic       protect_enable, comp_hyst_en, comp_pos_input_sel, comp_out_pin;
  logic       amp_cal_mode, amp_cal_ref_sel, comp_cal_mode, comp_cal_ref_sel;
  logic [5:0] amp_trim_code;
  logic [4:0] comp_trim_code;
  int         n_errors = 0;
  int         check_count = 0;
  int         u, w;
  protect_trim i_dut (.clk, .rst, .addr, .wdata, .wr_en, .rd_en, .rdata, .comp_in,
    .switch_ctrl, .threshold_dac_code, .protect_enable, .comp_hyst_en, .comp_pos_input_sel,
    .amp_cal_mode, .amp_cal_ref_sel, .amp_trim_code, .comp_cal_mode, .comp_cal_ref_sel,
    .comp_trim_code, .comp_out_pin);
  analog_front #(.AMP_TH(AMP_TH), .CMP_TH(CMP_TH)) i_front (.amp_cal_mode, .comp_cal_mode,
    .amp_trim_code, .comp_trim_code, .comp_pos_input_sel, .ext_level, .comp_in);
  always #5 clk = ~clk;
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : end_of_test
  // settle wait covers control update plus the two-flop sync and gate
  task automatic wr(input reg_addr_t a, input reg_byte_t d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : wr
  task automatic rd(input reg_addr_t a, output reg_byte_t d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 d = rdata;
  endtask : rd
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      n_errors++;
    end
  endtask : chk
  task automatic rc(input reg_addr_t a, input reg_byte_t e);
    reg_byte_t d;
    rd(a, d);
    chk("rdata", e, d);
  endtask : rc
  // stops at the range end if the output never flips
  task automatic sweep(input reg_addr_t a, input reg_byte_t pre, input int top,
                       input bit dn, output int res);
    reg_byte_t d;
    logic      first;
    res = dn ? top : 0;
    wr(a, pre | 8'(res));
    rd(3'h4, d);
    first = d[7];
    while (dn ? res > 0 : res < top) begin
      res = dn ? res - 1 : res + 1;
      wr(a, pre | 8'(res));
      rd(3'h4, d);
      if (d[7] !== first) break;
    end
  endtask : sweep
  task automatic t_regs;
    rc(3'h0, 8'hC8);
    rc(3'h3, 8'h20);
    rc(3'h4, 8'h10);
    wr(3'h3, 8'hC5);
    rc(3'h3, 8'hC5);
    chk("amp", 8'hC5, {amp_cal_mode, amp_cal_ref_sel, amp_trim_code});
    wr(3'h4, 8'hFF);
    rc(3'h4, 8'h7F);
    chk("comp", 8'h7F, {1'b0, comp_cal_mode, comp_cal_ref_sel, comp_trim_code});
    wr(3'h5, 8'hAA);
    rc(3'h5, 8'h00);
    wr(3'h1, 8'h3D);
    rc(3'h1, 8'h01);
    wr(3'h0, 8'h8F);
    chk("switch", 8'h8F, switch_ctrl);
    $display("registers done");
  endtask : t_regs
  task automatic t_enable;
    ext_level <= 1'b1;
    wr(3'h1, 8'h82);
    chk("enable", 8'h01, {7'h00, protect_enable});
    chk("insel", 8'h01, {7'h00, comp_pos_input_sel});
    rc(3'h4, 8'hFF);
    chk("pin", 8'h01, {7'h00, comp_out_pin});
    wr(3'h1, 8'h02);
    chk("enable", 8'h00, {7'h00, protect_enable});
    rc(3'h4, 8'h7F);
    chk("pin", 8'h00, {7'h00, comp_out_pin});
    ext_level <= 1'b0;
    $display("enable done");
  endtask : t_enable
  task automatic t_amp;
    wr(3'h0, 8'h28);
    chk("switch", 8'h28, switch_ctrl);
    wr(3'h3, 8'hC0);
    wr(3'h4, 8'h00);
    wr(3'h1, 8'h80);
    chk("insel", 8'h00, {7'h00, comp_pos_input_sel});
    wr(3'h2, 8'h40);
    chk("dac", 8'h40, threshold_dac_code);
    sweep(3'h3, 8'hC0, 63, 1'b0, u);
    sweep(3'h3, 8'hC0, 63, 1'b1, w);
    chk("up", 8'(AMP_TH), 8'(u));
    chk("down", 8'(AMP_TH - 1), 8'(w));
    wr(3'h3, 8'h40 | 8'((u + w) / 2));
    rc(3'h3, 8'h40 | 8'(AMP_TH - 1));
    $display("amplifier done");
  endtask : t_amp
  task automatic t_comp;
    wr(3'h1, 8'hC0);
    chk("hyst", 8'h01, {7'h00, comp_hyst_en});
    wr(3'h1, 8'h80);
    chk("hyst", 8'h00, {7'h00, comp_hyst_en});
    wr(3'h0, 8'h28);
    wr(3'h4, 8'h40);
    wr(3'h3, 8'h00);
    wr(3'h2, 8'h40);
    sweep(3'h4, 8'h40, 31, 1'b0, u);
    sweep(3'h4, 8'h40, 31, 1'b1, w);
    chk("up", 8'(CMP_TH), 8'(u));
    chk("down", 8'(CMP_TH - 1), 8'(w));
    wr(3'h4, 8'((u + w) / 2));
    rc(3'h4, 8'(CMP_TH - 1));
    $display("comparator done");
  endtask : t_comp
  initial begin
    rst = 1'b1;
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 3'h0;
    wdata = 8'h00;
    ext_level = 1'b0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_enable;
    t_amp;
    t_comp;
    end_of_test;
  end
  initial begin
    repeat (50000) @(posedge clk);
    n_errors++;
    end_of_test;
  end
endmodule : tb
